// ==== hdl/scsr_errq.sv ====
// Purpose: Error/event queue, oldest entry first
// Assumes: Push and pop are one-cycle strobes
// Notes:   A push into a full queue is dropped and flagged
`timescale 1ns/100ps
module scsr_errq (
  input  wire logic                        clk_i,
  input  wire logic                        rstn_i,
  input  wire logic                        push_i,
  input  wire logic [scsr_pkg::QCODE_W-1:0] code_i,
  input  wire logic                        pop_i,
  input  wire logic                        clr_i,
  output logic [scsr_pkg::QCODE_W-1:0]     head_o,
  output logic                             empty_o,
  output logic                             ovf_o
);

  scsr_pkg::scsr_q_t r;
  scsr_pkg::scsr_q_t n;
  logic              full;
  logic              do_push;
  logic              do_pop;

  always_comb begin
    n       = r;
    full    = (r.cnt == (scsr_pkg::QPTR_W+1)'(scsr_pkg::QDEPTH));
    do_push = push_i & ~full;
    do_pop  = pop_i & (r.cnt != '0);
    n.ovf   = push_i & full;
    if (do_push) begin
      n.mem[r.wp] = code_i;
      n.wp        = r.wp + 1'b1;
    end
    if (do_pop) begin
      n.rp = r.rp + 1'b1;
    end
    n.cnt = r.cnt + {3'h0, do_push} - {3'h0, do_pop};
    if (clr_i) begin
      n.wp  = '0;
      n.rp  = '0;
      n.cnt = '0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign head_o  = (r.cnt == '0) ? '0 : r.mem[r.rp];
  assign empty_o = (r.cnt == '0);
  assign ovf_o   = r.ovf;

endmodule // scsr_errq

// ==== hdl/scsr_pkg.sv ====
// Purpose: Shared constants and carriers of the status register model
// Assumes: 40 MHz clk_i, one clock domain
// Notes:   Byte addresses on a 10-bit Wishbone address
package scsr_pkg;

  // Register sets
  localparam int NSETS     = 11;
  localparam int SET_DEV   = 0;
  localparam int SET_OPER  = 1;
  localparam int SET_OCAL  = 2;
  localparam int SET_OLLF  = 3;
  localparam int SET_OMEAS = 4;
  localparam int SET_OSENS = 5;
  localparam int SET_OTRIG = 6;
  localparam int SET_OULF  = 7;
  localparam int SET_QUES  = 8;
  localparam int SET_QCAL  = 9;
  localparam int SET_QPOW  = 10;

  // Summary bit positions in parent sets, and the NVM failure bit of the device set
  localparam int OPER_CAL_BIT  = 0;
  localparam int OPER_MEAS_BIT = 4;
  localparam int OPER_TRIG_BIT = 5;
  localparam int OPER_SENS_BIT = 10;
  localparam int OPER_LLF_BIT  = 11;
  localparam int OPER_ULF_BIT  = 12;
  localparam int QUES_POW_BIT  = 3;
  localparam int QUES_CAL_BIT  = 8;
  localparam int DEV_NVM_BIT   = 3;

  typedef logic [14:0] scsr_word_t;

  // Address layout: set s at s*0x20, globals at 0x200
  localparam int ADR_W     = 10;
  localparam int ADR_GLB   = 9;
  localparam logic [2:0] F_COND = 3'h0;
  localparam logic [2:0] F_ENAB = 3'h1;
  localparam logic [2:0] F_EVT  = 3'h2;
  localparam logic [2:0] F_NTR  = 3'h3;
  localparam logic [2:0] F_PTR  = 3'h4;
  localparam logic [3:0] G_CMD  = 4'h0;
  localparam logic [3:0] G_ESR  = 4'h1;
  localparam logic [3:0] G_ESE  = 4'h2;
  localparam logic [3:0] G_STB  = 4'h3;
  localparam logic [3:0] G_SRE  = 4'h4;
  localparam logic [3:0] G_QUE  = 4'h5;
  localparam logic [3:0] G_QEN  = 4'h6;
  localparam logic [3:0] G_IRQ  = 4'h7;
  localparam logic [3:0] G_MSK  = 4'h8;

  // Command register bits
  localparam int CMD_CLS    = 0;
  localparam int CMD_PRESET = 1;
  localparam int CMD_RST    = 2;

  // Status byte bits
  localparam int STB_DEV = 1;
  localparam int STB_EAV = 2;
  localparam int STB_QUE = 3;
  localparam int STB_ESB = 5;
  localparam int STB_MSS = 6;
  localparam int STB_OPR = 7;

  // Preset and reset values
  localparam scsr_word_t PRE_PTR  = 15'h7fff;
  localparam scsr_word_t PRE_NTR  = 15'h0000;
  localparam scsr_word_t PRE_ENAB = 15'h0000;
  localparam logic       PRE_QEN  = 1'b1;

  // Error queue
  localparam int QDEPTH  = 8;
  localparam int QPTR_W  = 3;
  localparam int QCODE_W = 16;

  // Interrupt status bits
  localparam int IRQ_W    = 2;
  localparam int IRQ_SRQ  = 0;
  localparam int IRQ_QOVF = 1;

  typedef struct packed {
    scsr_word_t cond;
    scsr_word_t enab;
    scsr_word_t evt;
    scsr_word_t ntr;
    scsr_word_t ptr;
  } scsr_setregs_t;

  typedef struct packed {
    logic       wr;
    logic [2:0] fld;
    scsr_word_t wdat;
    logic       evt_clr;
    scsr_word_t clr_mask;
    logic       cls;
    logic       preset;
  } scsr_setctl_t;

  typedef struct packed {
    logic [QDEPTH-1:0][QCODE_W-1:0] mem;
    logic [QPTR_W-1:0]              wp;
    logic [QPTR_W-1:0]              rp;
    logic [QPTR_W:0]                cnt;
    logic                           ovf;
  } scsr_q_t;

  typedef struct packed {
    logic             ack;
    logic [31:0]      dat;
    logic [7:0]       esr;
    logic [7:0]       ese;
    logic [7:0]       sre;
    logic             qen;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] imsk;
    logic             mss;
    logic             rst;
  } scsr_top_t;

endpackage

// ==== hdl/scsr_set.sv ====
// Purpose: One register set: condition, filters, event, enable
// Assumes: Control arrives as one-cycle strobes from the bus slave
// Notes:   Set wins over clear on event bits
`timescale 1ns/100ps
module scsr_set (
  input  wire logic                   clk_i,
  input  wire logic                   rstn_i,
  input  wire scsr_pkg::scsr_word_t   cond_i,
  input  wire scsr_pkg::scsr_setctl_t ctl_i,
  output scsr_pkg::scsr_setregs_t     regs_o,
  output logic                        summary_o
);

  scsr_pkg::scsr_setregs_t r;
  scsr_pkg::scsr_setregs_t n;
  scsr_pkg::scsr_word_t    keep;

  always_comb begin
    n    = r;
    keep = r.evt;
    n.cond = cond_i;
    if (ctl_i.evt_clr) begin
      keep = keep & ~ctl_i.clr_mask;
    end
    if (ctl_i.cls) begin
      keep = '0;
    end
    n.evt = keep | (cond_i & ~r.cond & r.ptr) | (~cond_i & r.cond & r.ntr);
    if (ctl_i.preset) begin
      n.enab = scsr_pkg::PRE_ENAB;
      n.ntr  = scsr_pkg::PRE_NTR;
      n.ptr  = scsr_pkg::PRE_PTR;
    end
    if (ctl_i.wr) begin
      case (ctl_i.fld)
        scsr_pkg::F_ENAB: n.enab = ctl_i.wdat;
        scsr_pkg::F_NTR:  n.ntr  = ctl_i.wdat;
        scsr_pkg::F_PTR:  n.ptr  = ctl_i.wdat;
        default:          n.enab = n.enab;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r.cond <= '0;
      r.evt  <= '0;
      r.enab <= scsr_pkg::PRE_ENAB;
      r.ntr  <= scsr_pkg::PRE_NTR;
      r.ptr  <= scsr_pkg::PRE_PTR;
    end else begin
      r <= n;
    end
  end

  assign regs_o = r;
  assign summary_o = |(r.evt & r.enab);

endmodule // scsr_set

// ==== hdl/scsr_top.sv ====
// Purpose: Status reporting register model with a Wishbone slave
// Assumes: rstn_i is the power-on reset; inputs synchronous to clk_i
// Notes:   Register access answers one cycle after the request
`timescale 1ns/100ps
module scsr_top (
  input  wire logic                                    clk_i,
  input  wire logic                                    rstn_i,
  input  wire logic                                    wb_cyc_i,
  input  wire logic                                    wb_stb_i,
  input  wire logic                                    wb_we_i,
  input  wire logic [scsr_pkg::ADR_W-1:0]              wb_adr_i,
  input  wire logic [3:0]                              wb_sel_i,
  input  wire logic [31:0]                             wb_dat_i,
  output logic [31:0]                                  wb_dat_o,
  output logic                                         wb_ack_o,
  input  wire logic                                    nvm_fail_i,
  input  wire scsr_pkg::scsr_word_t [scsr_pkg::NSETS-1:0] cond_i,
  input  wire logic [7:0]                              esr_set_i,
  input  wire logic                                    err_push_i,
  input  wire logic [scsr_pkg::QCODE_W-1:0]            err_code_i,
  output logic [scsr_pkg::NSETS-1:0]                   summary_o,
  output logic                                         rst_cmd_o,
  output logic                                         irq_o
);

  scsr_pkg::scsr_top_t                         r;
  scsr_pkg::scsr_top_t                         n;
  scsr_pkg::scsr_setregs_t [scsr_pkg::NSETS-1:0] regs;
  scsr_pkg::scsr_setctl_t  [scsr_pkg::NSETS-1:0] ctl;
  scsr_pkg::scsr_word_t    [scsr_pkg::NSETS-1:0] cond_all;
  logic [scsr_pkg::NSETS-1:0]                  summ;
  logic [scsr_pkg::QCODE_W-1:0]                q_head;
  logic                                        q_empty;
  logic                                        q_ovf;
  logic                                        acc;
  logic                                        wr;
  logic                                        rd;
  logic                                        glb;
  logic [3:0]                                  set_idx;
  logic [2:0]                                  fld;
  logic [3:0]                                  gidx;
  logic                                        cls;
  logic                                        preset;
  logic [7:0]                                  stb_base;
  logic                                        mss;
  logic [7:0]                                  stb;
  logic [15:0]                                 wmerge;
  logic [31:0]                                 rdat;

  // Byte-lane merge of the low half word
  function automatic logic [15:0] lane16(input logic [15:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  sel);
    lane16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  // Address belongs to a register set
  function automatic logic is_set(input logic [scsr_pkg::ADR_W-1:0] a);
    is_set = !a[scsr_pkg::ADR_GLB] && (a[8:5] < 4'(scsr_pkg::NSETS)) && (a[4:2] <= scsr_pkg::F_PTR);
  endfunction

  // Bus decode; effects happen at the edge where ack is seen high
  assign acc     = wb_cyc_i & wb_stb_i & r.ack;
  assign wr      = acc & wb_we_i;
  assign rd      = acc & ~wb_we_i;
  assign glb     = wb_adr_i[scsr_pkg::ADR_GLB];
  assign set_idx = wb_adr_i[8:5];
  assign fld     = wb_adr_i[4:2];
  assign gidx    = wb_adr_i[5:2];
  assign cls     = wr && glb && (gidx == scsr_pkg::G_CMD) && wb_sel_i[0] && wb_dat_i[scsr_pkg::CMD_CLS];
  assign preset  = wr && glb && (gidx == scsr_pkg::G_CMD) && wb_sel_i[0] && wb_dat_i[scsr_pkg::CMD_PRESET];

  // Condition inputs, with summaries chained into parent sets
  always_comb begin
    cond_all = cond_i;
    cond_all[scsr_pkg::SET_DEV] = '0;
    cond_all[scsr_pkg::SET_DEV][scsr_pkg::DEV_NVM_BIT] = nvm_fail_i;
    cond_all[scsr_pkg::SET_OPER][scsr_pkg::OPER_CAL_BIT]  = summ[scsr_pkg::SET_OCAL];
    cond_all[scsr_pkg::SET_OPER][scsr_pkg::OPER_MEAS_BIT] = summ[scsr_pkg::SET_OMEAS];
    cond_all[scsr_pkg::SET_OPER][scsr_pkg::OPER_TRIG_BIT] = summ[scsr_pkg::SET_OTRIG];
    cond_all[scsr_pkg::SET_OPER][scsr_pkg::OPER_SENS_BIT] = summ[scsr_pkg::SET_OSENS];
    cond_all[scsr_pkg::SET_OPER][scsr_pkg::OPER_LLF_BIT]  = summ[scsr_pkg::SET_OLLF];
    cond_all[scsr_pkg::SET_OPER][scsr_pkg::OPER_ULF_BIT]  = summ[scsr_pkg::SET_OULF];
    cond_all[scsr_pkg::SET_QUES][scsr_pkg::QUES_CAL_BIT]  = summ[scsr_pkg::SET_QCAL];
    cond_all[scsr_pkg::SET_QUES][scsr_pkg::QUES_POW_BIT]  = summ[scsr_pkg::SET_QPOW];
  end

  assign wmerge = lane16(16'h0000, wb_dat_i, wb_sel_i);

  genvar gs;
  generate
    for (gs = 0; gs < scsr_pkg::NSETS; gs++) begin : g_set
      assign ctl[gs].wr       = wr && !glb && (set_idx == 4'(gs));
      assign ctl[gs].fld      = fld;
      assign ctl[gs].wdat     = wmerge[14:0];
      assign ctl[gs].evt_clr  = rd && !glb && (set_idx == 4'(gs)) && (fld == scsr_pkg::F_EVT);
      assign ctl[gs].clr_mask = r.dat[14:0];
      assign ctl[gs].cls      = cls;
      assign ctl[gs].preset   = preset;

      scsr_set u_set (
        .clk_i     (clk_i),
        .rstn_i    (rstn_i),
        .cond_i    (cond_all[gs]),
        .ctl_i     (ctl[gs]),
        .regs_o    (regs[gs]),
        .summary_o (summ[gs])
      );
    end
  endgenerate

  scsr_errq u_errq (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .push_i  (err_push_i & r.qen),
    .code_i  (err_code_i),
    .pop_i   (rd && glb && (gidx == scsr_pkg::G_QUE)),
    .clr_i   (cls),
    .head_o  (q_head),
    .empty_o (q_empty),
    .ovf_o   (q_ovf)
  );

  // Status byte from summaries; follows its sources when they clear
  always_comb begin
    stb_base = '0;
    stb_base[scsr_pkg::STB_DEV] = summ[scsr_pkg::SET_DEV];
    stb_base[scsr_pkg::STB_EAV] = ~q_empty;
    stb_base[scsr_pkg::STB_QUE] = summ[scsr_pkg::SET_QUES];
    stb_base[scsr_pkg::STB_ESB] = |(r.esr & r.ese);
    stb_base[scsr_pkg::STB_OPR] = summ[scsr_pkg::SET_OPER];
    mss = |(stb_base & r.sre);
    stb = stb_base;
    stb[scsr_pkg::STB_MSS] = mss;
  end

  // Read multiplexer
  always_comb begin
    rdat = '0;
    if (glb) begin
      case (gidx)
        scsr_pkg::G_ESR: rdat[7:0] = r.esr;
        scsr_pkg::G_ESE: rdat[7:0] = r.ese;
        scsr_pkg::G_STB: rdat[7:0] = stb;
        scsr_pkg::G_SRE: rdat[7:0] = r.sre;
        scsr_pkg::G_QUE: rdat[15:0] = q_head;
        scsr_pkg::G_QEN: rdat[0] = r.qen;
        scsr_pkg::G_IRQ: rdat[scsr_pkg::IRQ_W-1:0] = r.ist;
        scsr_pkg::G_MSK: rdat[scsr_pkg::IRQ_W-1:0] = r.imsk;
        default:         rdat = '0;
      endcase
    end else if (is_set(wb_adr_i)) begin
      case (fld)
        scsr_pkg::F_COND: rdat[14:0] = regs[set_idx].cond;
        scsr_pkg::F_ENAB: rdat[14:0] = regs[set_idx].enab;
        scsr_pkg::F_EVT:  rdat[14:0] = regs[set_idx].evt;
        scsr_pkg::F_NTR:  rdat[14:0] = regs[set_idx].ntr;
        scsr_pkg::F_PTR:  rdat[14:0] = regs[set_idx].ptr;
        default:          rdat = '0;
      endcase
    end
  end

  always_comb begin
    n     = r;
    n.ack = wb_cyc_i & wb_stb_i & ~r.ack;
    if (wb_cyc_i && wb_stb_i && !r.ack) begin
      n.dat = rdat;
    end
    n.rst = wr && glb && (gidx == scsr_pkg::G_CMD) && wb_sel_i[0] && wb_dat_i[scsr_pkg::CMD_RST];
    n.mss = mss;
    // ESR read or clear-status, new events win
    if (rd && glb && (gidx == scsr_pkg::G_ESR)) begin
      n.esr = r.esr & ~r.dat[7:0];
    end
    if (cls) begin
      n.esr = '0;
    end
    n.esr = n.esr | esr_set_i;
    if (preset) begin
      n.qen = scsr_pkg::PRE_QEN;
    end
    if (wr && glb && wb_sel_i[0]) begin
      case (gidx)
        scsr_pkg::G_ESE: n.ese = wb_dat_i[7:0];
        scsr_pkg::G_SRE: n.sre = wb_dat_i[7:0];
        scsr_pkg::G_QEN: n.qen = wb_dat_i[0];
        scsr_pkg::G_IRQ: n.ist = r.ist & ~wb_dat_i[scsr_pkg::IRQ_W-1:0];
        scsr_pkg::G_MSK: n.imsk = wb_dat_i[scsr_pkg::IRQ_W-1:0];
        default:         n.ese = n.ese;
      endcase
    end
    n.ist[scsr_pkg::IRQ_SRQ]  = n.ist[scsr_pkg::IRQ_SRQ] | (mss & ~r.mss);
    n.ist[scsr_pkg::IRQ_QOVF] = n.ist[scsr_pkg::IRQ_QOVF] | q_ovf;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r     <= '0;
      r.qen <= scsr_pkg::PRE_QEN;
    end else begin
      r <= n;
    end
  end

  assign wb_ack_o  = r.ack;
  assign wb_dat_o  = r.ack ? r.dat : 32'h0000_0000;
  assign summary_o = summ;
  assign rst_cmd_o = r.rst;
  assign irq_o     = |(r.ist & r.imsk);

endmodule // scsr_top

// ==== tb/scsr_host.sv ====
// Purpose: Host controller model issuing register accesses
// Assumes: Classic Wishbone single cycles
// Notes:   Released address and data lines show the inverse of the last value
`timescale 1ns/100ps
module scsr_host (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [9:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 10'h3ff;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'h3;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~a;
    dat_o <= ~d;
  endtask
endmodule // scsr_host

// ==== tb/scsr_properties.sv ====
// Purpose: Port-level checks of the status register model
// Assumes: Master leaves one idle cycle between accesses
// Notes:   Bound to scsr_top
`timescale 1ns/100ps
module scsr_properties (
  input wire logic                                       clk_i,
  input wire logic                                       rstn_i,
  input wire logic                                       wb_cyc_i,
  input wire logic                                       wb_stb_i,
  input wire logic                                       wb_we_i,
  input wire logic [scsr_pkg::ADR_W-1:0]                 wb_adr_i,
  input wire logic [3:0]                                 wb_sel_i,
  input wire logic [31:0]                                wb_dat_i,
  input wire logic [31:0]                                wb_dat_o,
  input wire logic                                       wb_ack_o,
  input wire logic                                       nvm_fail_i,
  input wire scsr_pkg::scsr_word_t [scsr_pkg::NSETS-1:0] cond_i,
  input wire logic [7:0]                                 esr_set_i,
  input wire logic                                       err_push_i,
  input wire logic [scsr_pkg::QCODE_W-1:0]               err_code_i,
  input wire logic [scsr_pkg::NSETS-1:0]                 summary_o,
  input wire logic                                       rst_cmd_o,
  input wire logic                                       irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd(a);
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == a;
  endsequence
  sequence s_wr(a);
    wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == a;
  endsequence
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_answer: assert property (s_req |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0 && (wb_adr_i[9] || !wb_dat_o[15]))
    else $error("upper read bits not zero");
  a_nvm_bit: assert property (s_rd(10'h000) ##0 $stable(nvm_fail_i)
    |=> wb_dat_o == {28'h0, $past(nvm_fail_i), 3'h0}) else $error("device condition wrong");
  a_evt_rdclr: assert property (s_rd(10'h048) ##0 $stable(cond_i[2]) ##1 $stable(cond_i[2])
    ##1 $stable(cond_i[2]) |=> summary_o[2] == 1'b0) else $error("event read did not clear");
  a_sum_cause: assert property ($rose(summary_o[2]) |-> $past(cond_i[2]) != $past(cond_i[2], 2)
    || $past(wb_ack_o && wb_we_i && wb_adr_i == 10'h044)) else $error("summary rose without cause");
  a_cls_leaf: assert property (s_wr(10'h200) ##0 wb_dat_i[0] ##0 $stable(cond_i)
    |=> summary_o[7:2] == 6'h0 && summary_o[10:9] == 2'h0) else $error("clear left events");
endmodule // scsr_properties

bind scsr_top scsr_properties scsr_properties_inst (
  .clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .nvm_fail_i(nvm_fail_i), .cond_i(cond_i), .esr_set_i(esr_set_i),
  .err_push_i(err_push_i), .err_code_i(err_code_i), .summary_o(summary_o),
  .rst_cmd_o(rst_cmd_o), .irq_o(irq_o));

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench of the status register model
// Assumes: 40 MHz clock, host model on the register bus
// Notes:   Each scenario is a task that judges its own results
`timescale 1ns/100ps
module testbench;
  logic                                       clk_i = 1'b0;
  logic                                       rstn_i = 1'b0;
  logic                                       nvm, push, ack, cyc, stb, we, irq, rcmd;
  logic [7:0]                                 esr;
  logic [15:0]                                code;
  logic [9:0]                                 adr;
  logic [3:0]                                 sel;
  logic [31:0]                                wdat, rdat;
  logic [10:0]                                summary_o;
  scsr_pkg::scsr_word_t [scsr_pkg::NSETS-1:0] cond;
  int                                         fails = 0;
  int                                         n_tests = 0;
  int                                         cyc_cnt = 0;
  always #12.5 clk_i = ~clk_i;
  scsr_host scsr_host_inst (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  scsr_top scsr_top_inst (.clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .nvm_fail_i(nvm), .cond_i(cond), .esr_set_i(esr), .err_push_i(push),
    .err_code_i(code), .summary_o(summary_o), .rst_cmd_o(rcmd), .irq_o(irq));
  task automatic test_done;
    if (fails == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      fails++;
      test_done;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask
  task automatic rc(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] q;
    scsr_host_inst.xfer(1'b0, a, 32'h0, q);
    chk($sformatf("register %h", a), e, q);
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    scsr_host_inst.xfer(1'b1, a, d, q);
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic t_power_on;
    for (int s = 0; s < scsr_pkg::NSETS; s++) begin
      rc(10'(s * 32 + 4), {17'h0, scsr_pkg::PRE_ENAB});
      rc(10'(s * 32 + 12), {17'h0, scsr_pkg::PRE_NTR});
      rc(10'(s * 32 + 16), {17'h0, scsr_pkg::PRE_PTR});
      rc(10'(s * 32 + 8), 32'h0);
    end
    rc(10'h218, {31'h0, scsr_pkg::PRE_QEN});
    rc(10'h208, 32'h0);
    rc(10'h210, 32'h0);
    rc(10'h20c, 32'h0);
  endtask
  task automatic t_width;
    int fl[3] = '{4, 12, 16};
    foreach (fl[i]) begin
      wr(10'(96 + fl[i]), 32'hffff_ffff);
      rc(10'(96 + fl[i]), 32'h7fff);
    end
    wr(10'h060, 32'hffff);
    rc(10'h060, 32'h0);
  endtask
  task automatic t_events;
    wr(10'h044, 32'h1);
    cond[2] <= 15'h1;
    ticks(2);
    chk("summary", 32'h1, {31'h0, summary_o[2]});
    rc(10'h040, 32'h1);
    rc(10'h040, 32'h1);
    rc(10'h048, 32'h1);
    rc(10'h048, 32'h0);
    wr(10'h04c, 32'h1);
    wr(10'h050, 32'h0);
    cond[2] <= 15'h0;
    ticks(2);
    rc(10'h048, 32'h1);
    cond[2] <= 15'h1;
    ticks(2);
    rc(10'h048, 32'h0);
  endtask
  task automatic t_nvm;
    nvm <= 1'b1;
    ticks(3);
    rc(10'h000, 32'h8);
    rc(10'h008, 32'h8);
    nvm <= 1'b0;
    cond[0] <= 15'h7fff;
    ticks(3);
    rc(10'h000, 32'h0);
  endtask
  task automatic t_commands;
    code <= 16'h0123;
    push <= 1'b1;
    esr <= 8'h01;
    ticks(2);
    push <= 1'b0;
    esr <= 8'h00;
    wr(10'h208, 32'hff);
    wr(10'h210, 32'h04);
    wr(10'h064, 32'h5);
    wr(10'h06c, 32'h5);
    wr(10'h070, 32'h0);
    wr(10'h218, 32'h0);
    wr(10'h084, 32'h1);
    cond[4] <= 15'h1;
    ticks(2);
    wr(10'h200, 32'h1 << scsr_pkg::CMD_RST);
    ticks(1);
    chk("rst_cmd", 32'h1, {31'h0, rcmd});
    ticks(1);
    chk("rst_cmd", 32'h0, {31'h0, rcmd});
    rc(10'h064, 32'h5);
    rc(10'h06c, 32'h5);
    rc(10'h218, 32'h0);
    rc(10'h210, 32'h4);
    rc(10'h20c, 32'h64);
    chk("summary", 32'h1, {31'h0, summary_o[4]});
    rc(10'h214, 32'h0123);
    wr(10'h200, 32'h1 << scsr_pkg::CMD_CLS);
    rc(10'h20c, 32'h0);
    rc(10'h214, 32'h0);
    rc(10'h088, 32'h0);
    rc(10'h064, 32'h5);
    rc(10'h208, 32'hff);
    rc(10'h218, 32'h0);
    cond[5] <= 15'h1;
    esr <= 8'h02;
    ticks(1);
    esr <= 8'h00;
    ticks(1);
    wr(10'h200, 32'h1 << scsr_pkg::CMD_PRESET);
    rc(10'h064, {17'h0, scsr_pkg::PRE_ENAB});
    rc(10'h06c, {17'h0, scsr_pkg::PRE_NTR});
    rc(10'h070, {17'h0, scsr_pkg::PRE_PTR});
    rc(10'h218, {31'h0, scsr_pkg::PRE_QEN});
    rc(10'h208, 32'hff);
    rc(10'h0a8, 32'h1);
    rc(10'h204, 32'h2);
  endtask
  task automatic t_irq;
    rc(10'h21c, 32'h1);
    wr(10'h220, 32'h1);
    ticks(1);
    chk("irq", 32'h1, {31'h0, irq});
    wr(10'h220, 32'h0);
    ticks(1);
    chk("irq", 32'h0, {31'h0, irq});
    wr(10'h220, 32'h1);
    wr(10'h21c, 32'h1);
    ticks(1);
    chk("irq", 32'h0, {31'h0, irq});
    rc(10'h21c, 32'h0);
    push <= 1'b1;
    ticks(9);
    push <= 1'b0;
    ticks(1);
    rc(10'h21c, 32'h3);
    chk("irq", 32'h1, {31'h0, irq});
  endtask
  task automatic t_reboot;
    rc(10'h3fc, 32'h0);
    cond <= '0;
    ticks(3);
    rstn_i <= 1'b0;
    ticks(2);
    rstn_i <= 1'b1;
    rc(10'h208, 32'h0);
    rc(10'h210, 32'h0);
    rc(10'h218, {31'h0, scsr_pkg::PRE_QEN});
  endtask
  initial begin
    nvm = 1'b0;
    push = 1'b0;
    esr = 8'h00;
    code = 16'h0;
    cond = '0;
    ticks(6);
    rstn_i <= 1'b1;
    t_power_on;
    t_width;
    t_events;
    t_nvm;
    t_commands;
    t_irq;
    t_reboot;
    test_done;
  end
endmodule // testbench
